// *** hdl/card_slot_interrupt_steering.sv ***
// interrupt steering for a card slot: sources, routing, waveforms, ack
// Operation
// - card request goes to one ISA line chosen by 4-bit field of 03h
// - status change goes to ISA line chosen by bits 7..4 of 05h
// - redirect bit sends status change to host pin, field ignored
// - unselected ISA lines stay high impedance
// - resume output needs detect change, resume enable and detect enable
// - only detect changes, from the detect pins or the software detect bit, ever reach the resume output
// - level mode: selected line floats, driven low while interrupt pends
// - edge mode: selected line driven low, driven high while pending
// - global bit 1 picks level mode, zero picks edge mode
// - line 14 override forces level waveform on line 14
// - host interrupt pin goes low exactly three clocks then high
// - card request clears once the card line returns high
// - reading status change register clears its bits
// - with write-back ack, writing ones clears those bits
// - I/O card sources: request, detect, status change line, gpi
// - memory card sources: detect, battery, ready, gpi changes
// - bit 5 of 03h: zero memory card, one I/O card
// - either detect input changing sets detect change bit
// - ready rising on memory card sets ready change bit
`timescale 1ns/10ps
module card_slot_interrupt_steering
    import card_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic card_detect1_n,
    input wire logic card_detect2_n,
    input wire logic card_req_n,
    input wire logic card_bvd1,
    input wire logic card_bvd2,
    input wire logic card_ready,
    input wire logic general_purpose_input,
    output logic [LINE_COUNT-1:0] irq_line_out,
    output logic [LINE_COUNT-1:0] irq_line_oe_n,
    output logic host_irq_pulse_n,
    output logic resume_wake_out_n
);
    typedef enum logic {PULSE_IDLE, PULSE_LOW} pulse_state_t;

    logic [DATA_W-1:0] int_gen_ctrl;
    logic [DATA_W-1:0] status_int_cfg;
    logic [DATA_W-1:0] detect_gen_ctrl;
    logic [DATA_W-1:0] global_ctrl;
    logic [SC_W-1:0] status_change;
    logic [SC_W-1:0] set_event;
    logic [SC_W-1:0] clear_mask;
    logic [SC_W-1:0] change_enable;
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] prev_pins;
    logic pins_valid;
    logic sync_warm1;
    logic sync_warm2;
    logic req_active;
    logic sc_pending;
    logic sc_pending_d;
    logic io_card;
    logic host_irq_redirect_en;
    logic line14_level_override;
    logic [LINE_COUNT-1:0] card_dest;
    logic [LINE_COUNT-1:0] sc_dest;
    logic [LINE_COUNT-1:0] selected;
    logic [LINE_COUNT-1:0] line_active;
    logic [LINE_COUNT-1:0] line_level;
    logic [LINE_COUNT-1:0] next_out;
    logic [LINE_COUNT-1:0] next_oe_n;
    logic [1:0] pulse_count;
    pulse_state_t pulse_state;
    logic wr_hit_status;
    logic rd_hit_status;

    // one-hot line for a selection code; illegal codes select nothing
    function automatic logic [LINE_COUNT-1:0] decode_line(
        input logic [SEL_W-1:0] code
    );
        logic [LINE_COUNT-1:0] onehot;
        onehot = '0;
        case (code)
            4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF:
                onehot[code] = 1'b1;
            default: onehot = '0;
        endcase
        return onehot;
    endfunction : decode_line

    pin_sync #(
        .WIDTH(PIN_COUNT)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in({general_purpose_input, card_ready, card_bvd2, card_bvd1,
                 card_req_n, card_detect2_n, card_detect1_n}),
        .pin_sync_out(pins)
    );

    assign io_card = int_gen_ctrl[IO_CARD_BIT];
    assign host_irq_redirect_en = int_gen_ctrl[HOST_REDIRECT_BIT];
    assign line14_level_override = global_ctrl[LINE14_OVR_BIT];
    assign wr_hit_status = reg_wr && (reg_addr == STATUS_CHANGE_IDX);
    assign rd_hit_status = reg_rd && (reg_addr == STATUS_CHANGE_IDX);

    // edges count only once prev_pins holds a synchronised pin sample
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_pins <= '0;
            sync_warm1 <= 1'b0;
            sync_warm2 <= 1'b0;
            pins_valid <= 1'b0;
        end else begin
            prev_pins <= pins;
            sync_warm1 <= 1'b1;
            sync_warm2 <= sync_warm1;
            pins_valid <= sync_warm2;
        end
    end

    // change detection per source
    always_comb begin
        set_event = '0;
        if (pins_valid) begin
            set_event[SC_DETECT_BIT] =
                (pins[PIN_CD1] ^ prev_pins[PIN_CD1]) |
                (pins[PIN_CD2] ^ prev_pins[PIN_CD2]);
            if (io_card) begin
                // status change line falls while ring indicate is off
                set_event[SC_DEAD_BIT] = !int_gen_ctrl[RING_ENABLE_BIT] &&
                    !pins[PIN_BVD1] && prev_pins[PIN_BVD1];
            end else begin
                set_event[SC_DEAD_BIT] = !pins[PIN_BVD1] &&
                    prev_pins[PIN_BVD1];
                set_event[SC_WARN_BIT] = (pins[PIN_BVD1] &&
                    !pins[PIN_BVD2]) && !(prev_pins[PIN_BVD1] &&
                    !prev_pins[PIN_BVD2]);
                set_event[SC_READY_BIT] = pins[PIN_READY] &&
                    !prev_pins[PIN_READY];
            end
            if (detect_gen_ctrl[GPI_ENABLE_BIT]) begin
                if (detect_gen_ctrl[GPI_FALL_BIT]) begin
                    set_event[SC_GPI_BIT] = !pins[PIN_GPI] &&
                        prev_pins[PIN_GPI];
                end else begin
                    set_event[SC_GPI_BIT] = pins[PIN_GPI] &&
                        !prev_pins[PIN_GPI];
                end
            end
        end
        if (reg_wr && (reg_addr == DETECT_GEN_CTRL_IDX) &&
            reg_wdata[SOFT_DETECT_BIT]) begin
            set_event[SC_DETECT_BIT] = 1'b1;
        end
    end

    // acknowledge: a read clears all, a write-back clears written ones
    always_comb begin
        clear_mask = '0;
        if (rd_hit_status) begin
            clear_mask = '1;
        end else if (wr_hit_status && global_ctrl[WRITE_ACK_BIT]) begin
            clear_mask = reg_wdata[SC_W-1:0];
        end
    end

    // a new event in the clearing cycle survives
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            status_change <= '0;
        end else begin
            status_change <= (status_change & ~clear_mask) | set_event;
        end
    end

    // control registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            int_gen_ctrl <= REG_RESET;
            status_int_cfg <= REG_RESET;
            detect_gen_ctrl <= REG_RESET;
            global_ctrl <= REG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == INT_GEN_CTRL_IDX) begin
                int_gen_ctrl <= reg_wdata;
            end else if (reg_addr == STATUS_INT_CFG_IDX) begin
                status_int_cfg <= reg_wdata;
            end else if (reg_addr == DETECT_GEN_CTRL_IDX) begin
                detect_gen_ctrl <= reg_wdata;
            end else if (reg_addr == GLOBAL_CTRL_IDX) begin
                global_ctrl <= reg_wdata;
            end
        end
    end

    // read data stands in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == IFACE_STATUS_IDX) begin
                reg_rdata <= {pins[PIN_GPI], 1'b0, pins[PIN_READY], 1'b0,
                              pins[PIN_CD2], pins[PIN_CD1],
                              pins[PIN_BVD2], pins[PIN_BVD1]};
            end else if (reg_addr == INT_GEN_CTRL_IDX) begin
                reg_rdata <= int_gen_ctrl;
            end else if (reg_addr == STATUS_CHANGE_IDX) begin
                reg_rdata <= {{(DATA_W-SC_W){1'b0}}, status_change};
            end else if (reg_addr == STATUS_INT_CFG_IDX) begin
                reg_rdata <= status_int_cfg;
            end else if (reg_addr == DETECT_GEN_CTRL_IDX) begin
                reg_rdata <= detect_gen_ctrl;
            end else if (reg_addr == GLOBAL_CTRL_IDX) begin
                reg_rdata <= global_ctrl;
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // card request: held until the card line returns high
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            req_active <= 1'b0;
        end else begin
            req_active <= io_card && pins_valid && !pins[PIN_REQ];
        end
    end

    assign change_enable = {detect_gen_ctrl[GPI_ENABLE_BIT],
                            status_int_cfg[SC_DETECT_BIT:SC_DEAD_BIT]};
    assign sc_pending = |(status_change & change_enable);

    assign card_dest = io_card ?
        decode_line(int_gen_ctrl[CARD_SEL_LSB +: SEL_W]) : '0;
    assign sc_dest = host_irq_redirect_en ? '0 :
        decode_line(status_int_cfg[SC_SEL_LSB +: SEL_W]);
    assign selected = card_dest | sc_dest;

    // per-line waveform shaping
    genvar n;
    generate
        for (n = 0; n < LINE_COUNT; n++) begin : g_line
            assign line_active[n] = (card_dest[n] && req_active) ||
                                    (sc_dest[n] && sc_pending);
            assign line_level[n] = global_ctrl[LEVEL_MODE_BIT] ||
                ((n == LINE14) && line14_level_override);
            always_comb begin
                if (!selected[n]) begin
                    next_oe_n[n] = 1'b1;
                    next_out[n] = 1'b0;
                end else if (line_level[n]) begin
                    next_oe_n[n] = !line_active[n];
                    next_out[n] = 1'b0;
                end else begin
                    next_oe_n[n] = 1'b0;
                    next_out[n] = line_active[n];
                end
            end

            a_unselected_float:
            assert property (@(posedge ref_clk) disable iff (reset)
                !$past(selected[n]) |-> irq_line_oe_n[n])
                else $error("unselected line is driven");
            a_level_drive:
            assert property (@(posedge ref_clk) disable iff (reset)
                $past(line_level[n] && line_active[n]) |->
                    !irq_line_oe_n[n] && !irq_line_out[n])
                else $error("level mode line not driven low while pending");
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_line_out <= '0;
            irq_line_oe_n <= '1;
        end else begin
            irq_line_out <= next_out;
            irq_line_oe_n <= next_oe_n;
        end
    end

    // host interrupt: three clock low pulse on each new status interrupt
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sc_pending_d <= 1'b0;
            pulse_state <= PULSE_IDLE;
            pulse_count <= '0;
            host_irq_pulse_n <= 1'b1;
        end else begin
            sc_pending_d <= sc_pending;
            case (pulse_state)
                PULSE_IDLE: begin
                    if (host_irq_redirect_en && sc_pending &&
                        !sc_pending_d) begin
                        pulse_state <= PULSE_LOW;
                        pulse_count <= HOST_PULSE_LOAD;
                        host_irq_pulse_n <= 1'b0;
                    end
                end
                PULSE_LOW: begin
                    if (pulse_count == '0) begin
                        pulse_state <= PULSE_IDLE;
                        host_irq_pulse_n <= 1'b1;
                    end else begin
                        pulse_count <= pulse_count - 2'd1;
                    end
                end
            endcase
        end
    end

    // resume output follows only a pending, enabled detect change
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resume_wake_out_n <= 1'b1;
        end else begin
            resume_wake_out_n <= !(status_change[SC_DETECT_BIT] &&
                detect_gen_ctrl[RESUME_EN_BIT] &&
                status_int_cfg[SC_DETECT_BIT]);
        end
    end

    a_host_pulse_width:
    assert property (@(posedge ref_clk) disable iff (reset)
        $fell(host_irq_pulse_n) |-> (!host_irq_pulse_n)[*3]
            ##1 host_irq_pulse_n)
        else $error("host pulse not three clocks long");
    a_resume_cause:
    assert property (@(posedge ref_clk) disable iff (reset)
        !resume_wake_out_n |-> $past(status_change[SC_DETECT_BIT]) &&
            $past(detect_gen_ctrl[RESUME_EN_BIT]) &&
            $past(status_int_cfg[SC_DETECT_BIT]))
        else $error("resume asserted without enabled detect change");
    a_read_clears:
    assert property (@(posedge ref_clk) disable iff (reset)
        rd_hit_status |=> (status_change & ~$past(set_event)) == '0)
        else $error("status read did not clear change bits");
    a_write_ack_clears:
    assert property (@(posedge ref_clk) disable iff (reset)
        wr_hit_status && global_ctrl[WRITE_ACK_BIT] |=>
            (status_change & $past(reg_wdata[SC_W-1:0]) &
             ~$past(set_event)) == '0)
        else $error("write-back did not clear written bits");
    a_detect_sets:
    assert property (@(posedge ref_clk) disable iff (reset)
        pins_valid && (pins[PIN_CD1] != prev_pins[PIN_CD1]) |=>
            status_change[SC_DETECT_BIT])
        else $error("detect change bit not set");
    a_ready_sets:
    assert property (@(posedge ref_clk) disable iff (reset)
        pins_valid && !io_card && pins[PIN_READY] &&
            !prev_pins[PIN_READY] |=> status_change[SC_READY_BIT])
        else $error("ready change bit not set");
    a_request_release:
    assert property (@(posedge ref_clk) disable iff (reset)
        req_active && pins[PIN_REQ] |=> !req_active)
        else $error("card request not removed after line rose");
    a_redirect_masks:
    assert property (@(posedge ref_clk) disable iff (reset)
        host_irq_redirect_en && (card_dest == '0) |=> irq_line_oe_n == '1)
        else $error("status change routed to line while redirected");
endmodule : card_slot_interrupt_steering

// *** hdl/card_irq_pkg.sv ***
// register map, field positions and timing constants for interrupt steering
package card_irq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LINE_COUNT = 16;
    localparam int PIN_COUNT = 7;

    localparam logic [7:0] IFACE_STATUS_IDX = 8'h01;
    localparam logic [7:0] INT_GEN_CTRL_IDX = 8'h03;
    localparam logic [7:0] STATUS_CHANGE_IDX = 8'h04;
    localparam logic [7:0] STATUS_INT_CFG_IDX = 8'h05;
    localparam logic [7:0] DETECT_GEN_CTRL_IDX = 8'h16;
    localparam logic [7:0] GLOBAL_CTRL_IDX = 8'h1E;

    localparam logic [7:0] REG_RESET = 8'h00;

    // interrupt and general control
    localparam int CARD_SEL_LSB = 0;
    localparam int HOST_REDIRECT_BIT = 4;
    localparam int IO_CARD_BIT = 5;
    localparam int RING_ENABLE_BIT = 7;
    // status interrupt configuration
    localparam int SC_SEL_LSB = 4;
    localparam int SEL_W = 4;
    // status change bits
    localparam int SC_DEAD_BIT = 0;
    localparam int SC_WARN_BIT = 1;
    localparam int SC_READY_BIT = 2;
    localparam int SC_DETECT_BIT = 3;
    localparam int SC_GPI_BIT = 4;
    localparam int SC_W = 5;
    // card detect and general control
    localparam int GPI_ENABLE_BIT = 2;
    localparam int GPI_FALL_BIT = 3;
    localparam int RESUME_EN_BIT = 4;
    localparam int SOFT_DETECT_BIT = 5;
    // global control
    localparam int LEVEL_MODE_BIT = 1;
    localparam int WRITE_ACK_BIT = 2;
    localparam int LINE14_OVR_BIT = 3;
    localparam int LINE14 = 14;

    // synchronised pin vector positions
    localparam int PIN_CD1 = 0;
    localparam int PIN_CD2 = 1;
    localparam int PIN_REQ = 2;
    localparam int PIN_BVD1 = 3;
    localparam int PIN_BVD2 = 4;
    localparam int PIN_READY = 5;
    localparam int PIN_GPI = 6;

    // host interrupt pulse, in clock pulses
    localparam int HOST_PULSE_CLOCKS = 3;
    localparam logic [1:0] HOST_PULSE_LOAD = 2'(HOST_PULSE_CLOCKS - 1);
endpackage : card_irq_pkg

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for a bank of card slot pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 7
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stage_one <= '0;
            pin_sync_out <= '0;
        end else begin
            stage_one <= pin_in;
            pin_sync_out <= stage_one;
        end
    end
endmodule : pin_sync

// *** verif/pc_card_model.sv ***
// behavioural pc card driving the slot pins of the socket
`timescale 1ns/10ps
module pc_card_model (
    input wire logic ref_clk,
    output logic card_detect1_n,
    output logic card_detect2_n,
    output logic card_req_n,
    output logic card_bvd1,
    output logic card_bvd2,
    output logic card_ready,
    output logic general_purpose_input
);
    // empty slot: detect pins rest at their pull-up level
    initial begin
        card_detect1_n = 1'b1;
        card_detect2_n = 1'b1;
        card_req_n = 1'b1;
        card_bvd1 = 1'b1;
        card_bvd2 = 1'b1;
        card_ready = 1'b0;
        general_purpose_input = 1'b0;
    end

    // both detect pins are grounded inside the card
    task automatic seat(input logic present);
        @(posedge ref_clk);
        card_detect1_n <= ~present;
        card_detect2_n <= ~present;
    endtask : seat

    // the card withdraws its request by letting the line return high
    task automatic request(input logic active);
        @(posedge ref_clk);
        card_req_n <= ~active;
    endtask : request

    task automatic lines(input logic b1, input logic b2, input logic rdy,
                         input logic gpi);
        @(posedge ref_clk);
        card_bvd1 <= b1;
        card_bvd2 <= b2;
        card_ready <= rdy;
        general_purpose_input <= gpi;
    endtask : lines
endmodule : pc_card_model

// *** verif/card_slot_interrupt_steering_tb_top.sv ***
// self-checking bench for card slot interrupt steering
`timescale 1ns/10ps
module card_slot_interrupt_steering_tb_top
    import card_irq_pkg::*;
;
    logic ref_clk;
    logic reset;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic card_detect1_n;
    logic card_detect2_n;
    logic card_req_n;
    logic card_bvd1;
    logic card_bvd2;
    logic card_ready;
    logic general_purpose_input;
    logic [LINE_COUNT-1:0] irq_line_out;
    logic [LINE_COUNT-1:0] irq_line_oe_n;
    logic host_irq_pulse_n;
    logic resume_wake_out_n;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int low_count;
    int codes[10] = '{3, 4, 5, 7, 9, 10, 11, 12, 14, 15};

    card_slot_interrupt_steering card_slot_interrupt_steering_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .card_detect1_n(card_detect1_n),
        .card_detect2_n(card_detect2_n),
        .card_req_n(card_req_n),
        .card_bvd1(card_bvd1),
        .card_bvd2(card_bvd2),
        .card_ready(card_ready),
        .general_purpose_input(general_purpose_input),
        .irq_line_out(irq_line_out),
        .irq_line_oe_n(irq_line_oe_n),
        .host_irq_pulse_n(host_irq_pulse_n),
        .resume_wake_out_n(resume_wake_out_n)
    );

    pc_card_model pc_card_model_inst (
        .ref_clk(ref_clk),
        .card_detect1_n(card_detect1_n),
        .card_detect2_n(card_detect2_n),
        .card_req_n(card_req_n),
        .card_bvd1(card_bvd1),
        .card_bvd2(card_bvd2),
        .card_ready(card_ready),
        .general_purpose_input(general_purpose_input)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_exp(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask : rd_exp

    // pin edge reaches the outputs four edges later
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : settle

    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        settle();
        chk(irq_line_oe_n, 16'hffff);
        chk(16'({host_irq_pulse_n, resume_wake_out_n}), 16'h3);
        wr(8'h20, 8'h5a);
        rd_exp(8'h20, 8'h00);
        // edge mode, status change on line 3
        wr(8'h05, 8'h38);
        settle();
        chk(irq_line_oe_n, 16'hfff7);
        chk(16'(irq_line_out[3]), 16'h0);
        pc_card_model_inst.seat(1'b1);
        settle();
        chk(16'(irq_line_out[3]), 16'h1);
        rd_exp(8'h04, 8'h08);
        settle();
        chk(16'(irq_line_out[3]), 16'h0);
        // level mode, write-back acknowledge
        wr(8'h1e, 8'h02);
        settle();
        chk(16'(irq_line_oe_n[3]), 16'h1);
        pc_card_model_inst.seat(1'b0);
        settle();
        chk(16'({irq_line_oe_n[3], irq_line_out[3]}), 16'h0);
        wr(8'h04, 8'h08);
        settle();
        chk(16'(irq_line_oe_n[3]), 16'h0);
        wr(8'h1e, 8'h06);
        wr(8'h04, 8'h08);
        settle();
        chk(16'(irq_line_oe_n[3]), 16'h1);
        // resume output
        wr(8'h16, 8'h10);
        pc_card_model_inst.seat(1'b1);
        settle();
        chk(16'(resume_wake_out_n), 16'h0);
        rd_exp(8'h04, 8'h08);
        settle();
        chk(16'(resume_wake_out_n), 16'h1);
        wr(8'h05, 8'h30);
        pc_card_model_inst.seat(1'b0);
        settle();
        chk(16'(resume_wake_out_n), 16'h1);
        rd_exp(8'h04, 8'h08);
        wr(8'h05, 8'h3c);
        pc_card_model_inst.lines(1'b1, 1'b1, 1'b1, 1'b0);
        settle();
        chk(16'(resume_wake_out_n), 16'h1);
        chk(16'(irq_line_oe_n[3]), 16'h0);
        rd_exp(8'h04, 8'h04);
        wr(8'h16, 8'h00);
        // redirect to the host pin
        wr(8'h03, 8'h10);
        settle();
        low_count = 0;
        pc_card_model_inst.seat(1'b1);
        repeat (10) begin
            @(posedge ref_clk);
            #1;
            if (host_irq_pulse_n === 1'b0) begin
                low_count++;
            end
        end
        chk(16'(low_count), 16'h3);
        chk(16'(irq_line_oe_n[3]), 16'h1);
        rd_exp(8'h04, 8'h08);
        // card request on every legal line, edge mode
        wr(8'h05, 8'h00);
        wr(8'h1e, 8'h00);
        foreach (codes[i]) begin
            wr(8'h03, 8'h20 | 8'(codes[i]));
            settle();
            chk(irq_line_oe_n, ~(16'h1 << codes[i]));
            pc_card_model_inst.request(1'b1);
            settle();
            chk(16'(irq_line_out[codes[i]]), 16'h1);
            pc_card_model_inst.request(1'b0);
            settle();
            chk(16'(irq_line_out[codes[i]]), 16'h0);
        end
        wr(8'h03, 8'h26);
        settle();
        chk(irq_line_oe_n, 16'hffff);
        wr(8'h03, 8'h03);
        pc_card_model_inst.request(1'b1);
        settle();
        chk(irq_line_oe_n, 16'hffff);
        pc_card_model_inst.request(1'b0);
        wr(8'h1e, 8'h08);
        wr(8'h03, 8'h2e);
        settle();
        chk(16'(irq_line_oe_n[14]), 16'h1);
        pc_card_model_inst.request(1'b1);
        settle();
        chk(16'({irq_line_oe_n[14], irq_line_out[14]}), 16'h0);
        pc_card_model_inst.request(1'b0);
        settle();
        chk(16'(irq_line_oe_n[14]), 16'h1);
        // status line, ring enable and gpi on an I/O card
        wr(8'h03, 8'h20);
        pc_card_model_inst.lines(1'b0, 1'b1, 1'b1, 1'b0);
        settle();
        rd_exp(8'h04, 8'h01);
        wr(8'h03, 8'ha0);
        pc_card_model_inst.lines(1'b1, 1'b1, 1'b1, 1'b0);
        settle();
        pc_card_model_inst.lines(1'b0, 1'b1, 1'b1, 1'b0);
        settle();
        rd_exp(8'h04, 8'h00);
        wr(8'h16, 8'h04);
        pc_card_model_inst.lines(1'b0, 1'b1, 1'b1, 1'b1);
        settle();
        rd_exp(8'h04, 8'h10);
        // battery warning on a memory card
        wr(8'h03, 8'h00);
        pc_card_model_inst.lines(1'b1, 1'b0, 1'b1, 1'b1);
        settle();
        rd_exp(8'h04, 8'h02);
        rd_exp(8'h01, 8'ha1);
        // falling gpi edge, then a software detect change
        wr(8'h16, 8'h0c);
        pc_card_model_inst.lines(1'b1, 1'b0, 1'b1, 1'b0);
        settle();
        rd_exp(8'h04, 8'h10);
        wr(8'h16, 8'h20);
        rd_exp(8'h04, 8'h08);
        close_out();
    end
endmodule : card_slot_interrupt_steering_tb_top
